//--- core/pafs_pkg.sv
package pafs_pkg;

  // Bus geometry
  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_P1_SEL = 10'h091;
  localparam logic [9:0] IDX_P3_SEL = 10'h093;
  localparam logic [9:0] IDX_P4_SEL = 10'h094;
  localparam logic [9:0] IDX_P1_LEVEL = 10'h0A1;
  localparam logic [9:0] IDX_P3_LEVEL = 10'h0A3;
  localparam logic [9:0] IDX_P4_LEVEL = 10'h0A4;
  localparam logic [9:0] IDX_P1_ACTIVE = 10'h0B1;
  localparam logic [9:0] IDX_P3_ACTIVE = 10'h0B3;
  localparam logic [9:0] IDX_P4_ACTIVE = 10'h0B4;

  // Reset values and writable bits of the selection registers
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] P1_SEL_MASK = 8'hF0;
  localparam logic [7:0] P3_SEL_MASK = 8'hC0;
  localparam logic [7:0] P4_SEL_MASK = 8'h0B;

  // Field positions
  localparam int unsigned P1_TIMER2_LSB = 0;
  localparam int unsigned P1_UART2_LSB = 2;
  localparam int unsigned P1_ANALOG_LSB = 4;
  localparam int unsigned P3_UART_LSB = 0;
  localparam int unsigned P3_EXT_INT_LSB = 2;
  localparam int unsigned P3_TIMER_LSB = 4;
  localparam int unsigned P3_SDA_BIT = 6;
  localparam int unsigned P3_SCL_BIT = 7;
  localparam int unsigned P4_DDC_SDA_BIT = 0;
  localparam int unsigned P4_DDC_SCL_BIT = 1;
  localparam int unsigned P4_PWM0_BIT = 3;

  // Position of each port in the packed pad arrays
  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned PORT_P1 = 0;
  localparam int unsigned PORT_P3 = 1;
  localparam int unsigned PORT_P4 = 2;

  // Level seen by a peripheral whose pin is not routed to it
  localparam logic [7:0] IDLE_INPUT = 8'hFF;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } pafs_drive_t;

  typedef pafs_drive_t [NUM_PORTS-1:0] pafs_drive_arr_t;
  typedef logic [NUM_PORTS-1:0][7:0] pafs_byte_arr_t;

  // Enables taken from the peripherals' own configuration registers
  typedef struct packed {
    logic timer2;
    logic uart2;
    logic uart;
    logic ext_int;
    logic timer;
  } pafs_periph_en_t;

endpackage

//--- core/pafs_port_mux.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Ports 0 and 2 belong to the external bus; none of their pins here.
// - Every pin is bidirectional; unselected pins act as plain GPIO.
// - A set selection bit routes the pin to its peripheral automatically.
// - Port 1 bits 7..4 select analog inputs 3..0; timer 2, UART 2 self-enable.
// - Port 1 pins 0..3 are GPIO while the timer 2 and UART 2 enables are low.
// - Port 3 pins 6 and 7 are GPIO or two-wire bus, never strobes.
// - After reset every selection bit is 0; a select-bit function needs its bit at 1.
// - Port 3 UART, interrupt, timer functions follow peripheral enables only.
// - Port 3: UART bits 0,1; interrupts 2,3; timers 4,5; two-wire 6,7.
// - Port 3 bit7 SCL, bit6 SDA; port 4 bit0 SDA, bit1 SCL, bit3 PWM0.
module pafs_port_mux
  import pafs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pafs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pafs_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pafs_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pafs_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pafs_pkg::pafs_periph_en_t periph_en,
  input wire pafs_pkg::pafs_drive_arr_t gpio_drive,
  output pafs_pkg::pafs_byte_arr_t gpio_in,
  input wire pafs_pkg::pafs_drive_arr_t alt_drive,
  output pafs_pkg::pafs_byte_arr_t alt_in,
  input wire pafs_pkg::pafs_byte_arr_t pad_in,
  output pafs_pkg::pafs_drive_arr_t pad_drive
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [9:0] aw_index;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [AXI_DATA_W-1:0] rdata;
    logic [7:0] p1_sel;
    logic [7:0] p3_sel;
    logic [7:0] p4_sel;
    pafs_byte_arr_t active;
    pafs_byte_arr_t gpio_in;
    pafs_byte_arr_t alt_in;
    pafs_drive_arr_t pad_drive;
  } pafs_state_t;

  pafs_state_t st;
  pafs_state_t next_st;

  // All outputs straight from the state register
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign gpio_in = st.gpio_in;
  assign alt_in = st.alt_in;
  assign pad_drive = st.pad_drive;

  // Bus handshakes, register file and pad routing, all in one pass
  always_comb
  begin
    pafs_byte_arr_t sel;
    logic [9:0] ar_index;
    logic [7:0] rd_byte;
    logic rd_hit;
    sel = '0;
    ar_index = s_axi_araddr[11:2];
    rd_byte = 8'h00;
    rd_hit = 1'b0;
    next_st = st;

    // Per-pin alternate select, port 1
    sel[PORT_P1][P1_TIMER2_LSB +: 2] = {2{periph_en.timer2}};
    sel[PORT_P1][P1_UART2_LSB +: 2] = {2{periph_en.uart2}};
    sel[PORT_P1][P1_ANALOG_LSB +: 4] = st.p1_sel[P1_ANALOG_LSB +: 4];

    // Port 3: low six bits ignore the selection register entirely
    sel[PORT_P3][P3_UART_LSB +: 2] = {2{periph_en.uart}};
    sel[PORT_P3][P3_EXT_INT_LSB +: 2] = {2{periph_en.ext_int}};
    sel[PORT_P3][P3_TIMER_LSB +: 2] = {2{periph_en.timer}};
    sel[PORT_P3][P3_SDA_BIT] = st.p3_sel[P3_SDA_BIT];
    sel[PORT_P3][P3_SCL_BIT] = st.p3_sel[P3_SCL_BIT];

    // Port 4: pins without a selection bit stay GPIO
    sel[PORT_P4][P4_DDC_SDA_BIT] = st.p4_sel[P4_DDC_SDA_BIT];
    sel[PORT_P4][P4_DDC_SCL_BIT] = st.p4_sel[P4_DDC_SCL_BIT];
    sel[PORT_P4][P4_PWM0_BIT] = st.p4_sel[P4_PWM0_BIT];

    // Pad mux; only ports 1, 3 and 4 exist in this block
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      next_st.active[p] = sel[p];
      // Alternate owner drives value and direction, else GPIO does
      next_st.pad_drive[p].dout = (sel[p] & alt_drive[p].dout)
                                | (~sel[p] & gpio_drive[p].dout);
      next_st.pad_drive[p].oe = (sel[p] & alt_drive[p].oe)
                              | (~sel[p] & gpio_drive[p].oe);
      // Idle-high input to an unrouted peripheral avoids false start bits
      next_st.alt_in[p] = (sel[p] & pad_in[p]) | (~sel[p] & IDLE_INPUT);
      // Software can always read the pad level, as on a classic port
      next_st.gpio_in[p] = pad_in[p];
    end

    // Write address channel
    if (s_axi_awvalid && st.awready)
    begin
      next_st.awready = 1'b0;
      next_st.have_aw = 1'b1;
      next_st.aw_index = s_axi_awaddr[11:2];
    end

    // Write data channel, may arrive before or after the address
    if (s_axi_wvalid && st.wready)
    begin
      next_st.wready = 1'b0;
      next_st.have_w = 1'b1;
      next_st.w_byte = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end

    // Perform the write once both halves are held
    if (st.have_aw && st.have_w && !st.bvalid)
    begin
      next_st.have_aw = 1'b0;
      next_st.have_w = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.aw_index == IDX_P1_SEL)
      begin
        if (st.w_lane0)
        begin
          next_st.p1_sel = st.w_byte & P1_SEL_MASK;
        end
      end
      else if (st.aw_index == IDX_P3_SEL)
      begin
        if (st.w_lane0)
        begin
          next_st.p3_sel = st.w_byte & P3_SEL_MASK;
        end
      end
      else if (st.aw_index == IDX_P4_SEL)
      begin
        if (st.w_lane0)
        begin
          next_st.p4_sel = st.w_byte & P4_SEL_MASK;
        end
      end
      else if (st.aw_index == IDX_P1_LEVEL || st.aw_index == IDX_P3_LEVEL
               || st.aw_index == IDX_P4_LEVEL || st.aw_index == IDX_P1_ACTIVE
               || st.aw_index == IDX_P3_ACTIVE || st.aw_index == IDX_P4_ACTIVE)
      begin
        next_st.bresp = RESP_OKAY; // Read-only, write ignored
      end
      else
      begin
        next_st.bresp = RESP_SLVERR;
      end
    end

    // Write response retires, channels reopen
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b0;
      next_st.wready = 1'b1;
    end

    // Read address decode
    if (ar_index == IDX_P1_SEL)
    begin
      rd_byte = st.p1_sel;
      rd_hit = 1'b1;
    end
    else if (ar_index == IDX_P3_SEL)
    begin
      rd_byte = st.p3_sel;
      rd_hit = 1'b1;
    end
    else if (ar_index == IDX_P4_SEL)
    begin
      rd_byte = st.p4_sel;
      rd_hit = 1'b1;
    end
    else if (ar_index == IDX_P1_LEVEL)
    begin
      rd_byte = st.gpio_in[PORT_P1];
      rd_hit = 1'b1;
    end
    else if (ar_index == IDX_P3_LEVEL)
    begin
      rd_byte = st.gpio_in[PORT_P3];
      rd_hit = 1'b1;
    end
    else if (ar_index == IDX_P4_LEVEL)
    begin
      rd_byte = st.gpio_in[PORT_P4];
      rd_hit = 1'b1;
    end
    else if (ar_index == IDX_P1_ACTIVE)
    begin
      rd_byte = st.active[PORT_P1];
      rd_hit = 1'b1;
    end
    else if (ar_index == IDX_P3_ACTIVE)
    begin
      rd_byte = st.active[PORT_P3];
      rd_hit = 1'b1;
    end
    else if (ar_index == IDX_P4_ACTIVE)
    begin
      rd_byte = st.active[PORT_P4];
      rd_hit = 1'b1;
    end

    // Read channel; one read in flight, data presented the edge after
    if (s_axi_arvalid && st.arready)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = {24'h000000, rd_byte};
      next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  // State register; reset makes every pin plain GPIO and tristated
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.bresp <= RESP_OKAY;
      st.rresp <= RESP_OKAY;
      st.p1_sel <= SEL_RESET;
      st.p3_sel <= SEL_RESET;
      st.p4_sel <= SEL_RESET;
      st.alt_in <= {NUM_PORTS{IDLE_INPUT}};
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule // pafs_port_mux

//--- dv/pafs_port_mux_checker.sv
`timescale 1ns/1ps
// Pin routing and bus timing checks, port view only
module pafs_port_mux_checker
  import pafs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire pafs_pkg::pafs_periph_en_t periph_en,
  input wire pafs_pkg::pafs_drive_arr_t gpio_drive,
  input wire pafs_pkg::pafs_byte_arr_t gpio_in,
  input wire pafs_pkg::pafs_drive_arr_t alt_drive,
  input wire pafs_pkg::pafs_byte_arr_t alt_in,
  input wire pafs_pkg::pafs_byte_arr_t pad_in,
  input wire pafs_pkg::pafs_drive_arr_t pad_drive
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Guarded by past reset so the first edge out of reset is skipped
  a_gpio_in_pad: assert property ($past(aresetn) |-> gpio_in == $past(pad_in))
    else $error("gpio input does not follow pad");
  a_p1_timer2: assert property ($past(aresetn) |-> pad_drive[0].dout[1:0] ==
    $past(periph_en.timer2 ? alt_drive[0].dout[1:0] : gpio_drive[0].dout[1:0]))
    else $error("port1 timer2 pins misrouted");
  a_p3_uart: assert property ($past(aresetn) |-> pad_drive[1].oe[1:0] ==
    $past(periph_en.uart ? alt_drive[1].oe[1:0] : gpio_drive[1].oe[1:0]))
    else $error("port3 uart pins misrouted");
  a_p3_timer: assert property ($past(aresetn) |-> pad_drive[1].dout[5:4] ==
    $past(periph_en.timer ? alt_drive[1].dout[5:4] : gpio_drive[1].dout[5:4]))
    else $error("port3 timer pins misrouted");
  a_p4_plain: assert property ($past(aresetn) |->
    (pad_drive[2] & 16'hF4F4) == $past(gpio_drive[2] & 16'hF4F4))
    else $error("port4 unselectable pins not plain");
  a_reset_plain: assert property ($rose(aresetn) |-> alt_in == {3{8'hFF}} &&
    {pad_drive[0].oe, pad_drive[1].oe, pad_drive[2].oe} == 24'h0)
    else $error("pins not plain after reset");
  // Both halves held one edge after the handshake, answer registered the edge after that
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
endmodule // pafs_port_mux_checker

bind pafs_port_mux pafs_port_mux_checker i_pafs_port_mux_checker (.*);

//--- dv/pafs_pad_model.sv
`timescale 1ns/1ps
// Board pads: a driven pin shows its driver, a released one the board level
module pafs_pad_model
  import pafs_pkg::*;
(
  input wire pafs_pkg::pafs_drive_arr_t pad_drive,
  input wire pafs_pkg::pafs_byte_arr_t board_lvl,
  output pafs_pkg::pafs_byte_arr_t pad_in
);
  // Wire level resolved per pin from the enable
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      pad_in[p] = (pad_drive[p].oe & pad_drive[p].dout)
                | (~pad_drive[p].oe & board_lvl[p]);
    end
  end
endmodule // pafs_pad_model

//--- dv/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
  import pafs_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [AXI_DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] d;
  pafs_periph_en_t periph_en = '0;
  pafs_drive_arr_t gpio_drive = '0, alt_drive = '0, pad_drive;
  pafs_byte_arr_t gpio_in, alt_in, pad_in, board_lvl = '0;
  int miscompares = 0, cmp_count = 0;

  always #2.5 aclk = ~aclk;
  pafs_port_mux i_pafs_port_mux (.*);
  pafs_pad_model i_pafs_pad_model (.*);

  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One bus transfer; each valid held until its own ready edge
  task automatic acc(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_araddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, wd};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      n++;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
    if (n >= 40)
    begin
      miscompares++;
      conclude();
    end
    r = w ? s_axi_bresp : s_axi_rresp;
    d = s_axi_rdata[7:0];
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask

  // Reset values, writable bits, lane strobe, read-only and unmapped indices
  task automatic t_regs();
    logic [9:0] idx[3] = '{IDX_P1_SEL, IDX_P3_SEL, IDX_P4_SEL};
    logic [7:0] msk[3] = '{P1_SEL_MASK, P3_SEL_MASK, P4_SEL_MASK};
    for (int i = 0; i < 3; i++)
    begin
      acc(1'h0, idx[i], 8'h00);
      `CHK(d, SEL_RESET)
      acc(1'h1, idx[i], 8'hFF);
      acc(1'h0, idx[i], 8'h00);
      `CHK(d, msk[i])
      `CHK(r, RESP_OKAY)
    end
    // Lane 0 strobe low must leave the register untouched
    s_axi_wstrb <= 4'hE;
    acc(1'h1, IDX_P4_SEL, 8'h00);
    `CHK(r, RESP_OKAY)
    s_axi_wstrb <= 4'hF;
    acc(1'h0, IDX_P4_SEL, 8'h00);
    `CHK(d, P4_SEL_MASK)
    acc(1'h1, IDX_P1_LEVEL, 8'hFF);
    `CHK(r, RESP_OKAY)
    acc(1'h1, 10'h092, 8'hFF);
    `CHK(r, RESP_SLVERR)
    acc(1'h0, 10'h092, 8'h00);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 8'h00)
  endtask

  // Every pin follows its select bit or peripheral enable, four enable mixes
  task automatic t_route(input logic [7:0] s1, input logic [7:0] s3, input logic [7:0] s4);
    logic [4:0] pe[4] = '{5'h00, 5'h15, 5'h0A, 5'h1F};
    logic [9:0] ai[3] = '{IDX_P1_ACTIVE, IDX_P3_ACTIVE, IDX_P4_ACTIVE};
    logic [9:0] li[3] = '{IDX_P1_LEVEL, IDX_P3_LEVEL, IDX_P4_LEVEL};
    logic [7:0] m[3];
    logic [7:0] xo, xd, lv;
    acc(1'h1, IDX_P1_SEL, s1);
    acc(1'h1, IDX_P3_SEL, s3);
    acc(1'h1, IDX_P4_SEL, s4);
    for (int k = 0; k < 4; k++)
    begin
      periph_en <= pe[k];
      repeat (3) @(posedge aclk);
      m[0] = (s1 & 8'hF0) | {4'h0, {2{periph_en.uart2}}, {2{periph_en.timer2}}};
      m[1] = (s3 & 8'hC0) | {2'h0, {2{periph_en.timer}}, {2{periph_en.ext_int}},
        {2{periph_en.uart}}};
      m[2] = s4 & 8'h0B;
      for (int p = 0; p < 3; p++)
      begin
        xo = (alt_drive[p].oe & m[p]) | (gpio_drive[p].oe & ~m[p]);
        xd = (alt_drive[p].dout & m[p]) | (gpio_drive[p].dout & ~m[p]);
        lv = (xo & xd) | (~xo & board_lvl[p]);
        `CHK(pad_drive[p].oe, xo)
        `CHK(pad_drive[p].dout, xd)
        `CHK(alt_in[p], lv | ~m[p])
        `CHK(gpio_in[p], lv)
        // Software view of the effective selection and of the pad level
        acc(1'h0, ai[p], 8'h00);
        `CHK(d, m[p])
        acc(1'h0, li[p], 8'h00);
        `CHK(d, lv)
      end
    end
  endtask

  // Mid-run reset drops every selection back to plain pins
  task automatic t_rst();
    acc(1'h1, IDX_P1_SEL, 8'hFF);
    acc(1'h1, IDX_P3_SEL, 8'hFF);
    acc(1'h1, IDX_P4_SEL, 8'hFF);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    `CHK({pad_drive[0].oe, pad_drive[1].oe, pad_drive[2].oe}, 24'h0)
    `CHK(alt_in, {NUM_PORTS{IDLE_INPUT}})
    aresetn <= 1'h1;
    acc(1'h0, IDX_P1_SEL, 8'h00);
    `CHK(d, SEL_RESET)
    acc(1'h0, IDX_P3_SEL, 8'h00);
    `CHK(d, SEL_RESET)
    acc(1'h0, IDX_P4_SEL, 8'h00);
    `CHK(d, SEL_RESET)
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    gpio_drive <= {3{16'hA53C}};
    // Enables opposite to the GPIO ones so every pin's routing is visible
    alt_drive <= {3{16'h5AC3}};
    board_lvl <= {3{8'h96}};
    t_regs();
    t_route(8'hFF, 8'hFF, 8'hFF);
    t_route(8'h50, 8'h80, 8'h09);
    t_route(8'h00, 8'h00, 8'h00);
    t_rst();
    conclude();
  end
endmodule // tb
